// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic        clk_sys;
    logic        srst;
    logic [2:0]  addr;
    logic [15:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [15:0] rd_data;
    wire logic   first_capture_pin;
    wire logic   second_capture_pin;
    logic        timer_output_pin;
    logic        first_match_capture_irq;
    logic        second_match_capture_irq;
    int          n_errors = 0;
    int          comparisons = 0;
    int          n_irq1 = 0;
    int          n_irq2 = 0;
    int          a1;
    int          a2;
    int          d;
    int          h;
    logic [15:0] m;
    logic [15:0] n;
    logic [15:0] v;
    logic [15:0] c0;

    tpg_timer i_tpg_timer (.clk_sys(clk_sys), .srst(srst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .first_capture_pin(first_capture_pin), .second_capture_pin(second_capture_pin),
        .timer_output_pin(timer_output_pin), .first_match_capture_irq(first_match_capture_irq),
        .second_match_capture_irq(second_match_capture_irq));
    tpg_pin_src i_tpg_pin_src (.clk_sys(clk_sys), .first_capture_pin(first_capture_pin),
        .second_capture_pin(second_capture_pin));

    // ==========================================================
    // clock and interrupt pulse tally
    initial clk_sys = 1'b0;
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (first_match_capture_irq === 1'b1) n_irq1 <= n_irq1 + 1;
        if (second_match_capture_irq === 1'b1) n_irq2 <= n_irq2 + 1;
    end

    // ==========================================================
    // helpers
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] dat);
        @(posedge clk_sys);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= dat;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [15:0] dat);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        dat = rd_data;
    endtask
    // cycles until the output shows lv, capped at lim
    task automatic wait_lvl(input logic lv, input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim) begin
            @(posedge clk_sys);
            #1;
            cnt++;
            if (timer_output_pin === lv) break;
        end
    endtask
    // stop first so a half-written setup never runs
    task automatic setup(input logic [15:0] c1, c2, cfg, oc, mode);
        wr(tpg_pkg::REG_MODE_CTRL, 16'h0000);
        wr(tpg_pkg::REG_CMP_FIRST, c1);
        wr(tpg_pkg::REG_CMP_SECOND, c2);
        wr(tpg_pkg::REG_CAP_CFG, cfg);
        wr(tpg_pkg::REG_OUT_CTRL, oc);
        wr(tpg_pkg::REG_PRESCALE, 16'h0000); // internal count clock only
        wr(tpg_pkg::REG_MODE_CTRL, mode);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog, sized above the overflow wait
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end

    // ==========================================================
    // main sequence
    initial begin
        srst = 1'b1; addr = 3'h0; wr_data = 16'h0000; wr_en = 1'b0; rd_en = 1'b0;
        void'($urandom(32'h017A));
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        // reset values, unmapped index, read-only counter
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), v);
            chk("reset_value", 16'h0000, v);
        end
        wr(3'h7, 16'hABCD);
        rd(3'h7, v);
        chk("unmapped", 16'h0000, v);
        wr(tpg_pkg::REG_COUNTER, 16'h1234);
        rd(tpg_pkg::REG_COUNTER, v);
        chk("counter_ro", 16'h0000, v);
        m = 16'($urandom);
        wr(tpg_pkg::REG_CMP_FIRST, m);
        rd(tpg_pkg::REG_CMP_FIRST, v);
        chk("cmp_rw", m, v);
        wr(tpg_pkg::REG_OUT_CTRL, 16'h0061);
        rd(tpg_pkg::REG_OUT_CTRL, v);
        chk("trigger_self_clears", 16'h0021, v);
        // periodic pulse: width cmp2+1, period cmp1+1, one irq each per period
        for (int i = 0; i < 2; i++) begin
            m = (i == 0) ? 16'h0005 : 16'($urandom_range(30, 4));
            n = (i == 0) ? 16'h0000 : 16'($urandom_range(m - 1, 0));
            setup(m, n, 16'h0000, 16'h0001, 16'h000C);
            // second pass halves the count clock, so every span doubles
            if (i == 1) wr(tpg_pkg::REG_PRESCALE, 16'h0001);
            wait_lvl(1'b0, 100, d);
            wait_lvl(1'b1, 100, d);
            wait_lvl(1'b0, 100, h);
            wait_lvl(1'b1, 100, d);
            chk("ppg_width", (n + 16'h0001) << i, 16'(h));
            chk("ppg_period", (m + 16'h0001) << i, 16'(h + d));
            a1 = n_irq1;
            a2 = n_irq2;
            repeat ((2 * (m + 1)) << i) @(posedge clk_sys);
            #1;
            chk("ppg_irq1", 16'h0002, 16'(n_irq1 - a1));
            chk("ppg_irq2", 16'h0002, 16'(n_irq2 - a2));
        end
        // one-shot: soft trigger in free mode, pin trigger in edge mode with swapped values
        for (int i = 0; i < 2; i++) begin
            m = 16'($urandom_range(30, 10));
            n = m + 16'($urandom_range(40, 1)); // never equal values
            if (i == 0) setup(m, n, 16'h0010, 16'h0021, 16'h0004);
            else setup(n, m, 16'h0010, 16'h0021, 16'h0008);
            a1 = n_irq1;
            a2 = n_irq2;
            if (i == 0) wr(tpg_pkg::REG_OUT_CTRL, 16'h0061);
            else i_tpg_pin_src.set_pin(1'b0, 1'b1);
            wait_lvl(1'b1, 200, d);
            chk("os_delay", 16'h0001, 16'(d >= m + 1 && d <= m + 8));
            wait_lvl(1'b0, 200, d);
            chk("os_width", n - m, 16'(d));
            repeat (3) @(posedge clk_sys);
            chk("os_irq1", 16'h0001, 16'(n_irq1 - a1));
            chk("os_irq2", 16'h0001, 16'(n_irq2 - a2));
            wait_lvl(1'b1, 300, d);
            chk("os_single", 16'h012C, 16'(d));
            i_tpg_pin_src.set_pin(1'b0, 1'b0);
        end
        // two-pin capture: first pin to second register, second pin to first
        setup(16'h0000, 16'h0000, 16'h0055, 16'h0000, 16'h0004);
        repeat (40) @(posedge clk_sys);
        for (int s = 0; s < 2; s++) begin
            a1 = n_irq1;
            a2 = n_irq2;
            rd(tpg_pkg::REG_COUNTER, c0);
            i_tpg_pin_src.set_pin(s[0], 1'b1);
            repeat (10) @(posedge clk_sys);
            rd(s ? tpg_pkg::REG_CMP_FIRST : tpg_pkg::REG_CMP_SECOND, v);
            chk("cap_value", 16'h0001, 16'(v > c0 && v < c0 + 16));
            chk("cap_irq", 16'h0001, 16'(s ? n_irq1 - a1 : n_irq2 - a2));
            chk("cap_other", 16'h0000, 16'(s ? n_irq2 - a2 : n_irq1 - a1));
        end
        i_tpg_pin_src.set_pin(1'b0, 1'b0);
        i_tpg_pin_src.set_pin(1'b1, 1'b0);
        // one-pin width: free mode and clear-and-start mode
        for (int k = 0; k < 2; k++) begin
            setup(16'h0000, 16'h0000, 16'h0017, 16'h0000, k ? 16'h0008 : 16'h0004);
            repeat (30) @(posedge clk_sys);
            i_tpg_pin_src.set_pin(1'b0, 1'b1);
            repeat (10) @(posedge clk_sys);
            rd(tpg_pkg::REG_COUNTER, c0);
            rd(tpg_pkg::REG_CMP_SECOND, n);
            chk("valid_capture", 16'h0001, 16'(n >= 16'h001E));
            chk("edge_clear", 16'(k), 16'(c0 < 16));
            h = $urandom_range(60, 20);
            repeat (h) @(posedge clk_sys);
            i_tpg_pin_src.set_pin(1'b0, 1'b0);
            repeat (10) @(posedge clk_sys);
            rd(tpg_pkg::REG_CMP_FIRST, m);
            v = k ? m : m - n; // no wrap inside the window, nothing to add
            chk("opposite_capture", 16'h0001, 16'(v + 2 >= h + 15 && v <= h + 17));
        end
        // overflow sets the flag, it sticks, a zero write clears it
        setup(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0004);
        repeat (65560) @(posedge clk_sys);
        rd(tpg_pkg::REG_MODE_CTRL, v);
        chk("ovf_set", 16'h0005, v);
        repeat (10) @(posedge clk_sys);
        rd(tpg_pkg::REG_MODE_CTRL, v);
        chk("ovf_sticks", 16'h0005, v);
        wr(tpg_pkg::REG_MODE_CTRL, 16'h0004);
        rd(tpg_pkg::REG_MODE_CTRL, v);
        chk("ovf_cleared", 16'h0004, v);
        print_verdict();
    end
endmodule

`default_nettype wire

// file: tpg_edge_if.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// synchronised edge pulses of the two capture pins
interface tpg_edge_if;
    logic first_rise;
    logic first_fall;
    logic second_rise;
    logic second_fall;

    modport src (output first_rise, output first_fall, output second_rise, output second_fall);
    modport dst (input first_rise, input first_fall, input second_rise, input second_fall);
endinterface

`default_nettype wire

// file: tpg_pin_src.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// external pulse source on the two capture pins
module tpg_pin_src (
    input  wire logic clk_sys,
    output var logic  first_capture_pin,
    output var logic  second_capture_pin
);
    // pins idle low and never move unless a scenario asks, so
    // software-only triggering sees no stray edges
    initial begin
        first_capture_pin  = 1'b0;
        second_capture_pin = 1'b0;
    end

    // a level change lands just after an edge and then stays put
    task automatic set_pin(input logic sel, input logic lv);
        @(posedge clk_sys);
        if (sel) begin
            second_capture_pin <= lv;
        end else begin
            first_capture_pin <= lv;
        end
    endtask
endmodule

`default_nettype wire

// file: tpg_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module tpg_pin_sync (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic first_capture_pin,
    input  wire logic second_capture_pin,
    tpg_edge_if.src   edge_out
);

    typedef struct packed {
        logic [1:0] ff1;
        logic [1:0] ff2;
        logic [1:0] ff3;
        logic [1:0] lvl;
        logic [1:0] rise;
        logic [1:0] fall;
    } tpg_sync_type;

    tpg_sync_type s_q;
    tpg_sync_type s_d;

    // ==========================================================
    // three stages; a change counts once stages two and three agree
    always_comb begin
        s_d      = s_q;
        s_d.ff1  = {second_capture_pin, first_capture_pin};
        s_d.ff2  = s_q.ff1;
        s_d.ff3  = s_q.ff2;
        s_d.rise = 2'h0;
        s_d.fall = 2'h0;
        for (int i = 0; i < 2; i++) begin
            if (s_q.ff2[i] == s_q.ff3[i] && s_q.ff3[i] != s_q.lvl[i]) begin
                s_d.lvl[i]  = s_q.ff3[i];
                s_d.rise[i] = s_q.ff3[i];
                s_d.fall[i] = ~s_q.ff3[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign edge_out.first_rise  = s_q.rise[0];
    assign edge_out.first_fall  = s_q.fall[0];
    assign edge_out.second_rise = s_q.rise[1];
    assign edge_out.second_fall = s_q.fall[1];

    // one pulse per settled change, never both directions at once
    single_edge_a: assert property (@(posedge clk_sys) disable iff (srst)
        s_q.rise[0] |=> !s_q.rise[0] && !s_q.fall[0])
        else $error("capture pin edge pulse longer than one cycle");

endmodule

`default_nettype wire

// file: tpg_pkg.sv
package tpg_pkg;

    // ==========================================================
    // register indices on the plain register port
    localparam logic [2:0] REG_COUNTER    = 3'h0;
    localparam logic [2:0] REG_CMP_FIRST  = 3'h1;
    localparam logic [2:0] REG_CMP_SECOND = 3'h2;
    localparam logic [2:0] REG_MODE_CTRL  = 3'h3;
    localparam logic [2:0] REG_OUT_CTRL   = 3'h4;
    localparam logic [2:0] REG_CAP_CFG    = 3'h5;
    localparam logic [2:0] REG_PRESCALE   = 3'h6;

    // ==========================================================
    // field positions
    localparam int MODE_OVF_BIT   = 0;
    localparam int MODE_FIELD_LO  = 2;
    localparam int OUT_ENABLE_BIT = 0;
    localparam int OUT_OSE_BIT    = 5;
    localparam int OUT_OST_BIT    = 6;
    localparam int CAP_FIRST_BIT  = 0;
    localparam int CAP_FSRC_BIT   = 1;
    localparam int CAP_SECOND_BIT = 2;
    localparam int CAP_FEDGE_LO   = 4;
    localparam int CAP_SEDGE_LO   = 6;

    // ==========================================================
    // reset values and fixed counts
    localparam logic [15:0] CNT_RESET   = 16'h0000;
    localparam logic [15:0] CNT_TOP     = 16'hFFFF;
    localparam logic [15:0] CMP_RESET   = 16'h0000;
    localparam logic [7:0]  CAP_RESET   = 8'h00;
    localparam logic [2:0]  PRESC_RESET = 3'h0;

    // ==========================================================
    // modes and edge selects
    typedef enum logic [1:0] {
        TPG_MODE_STOP  = 2'b00,
        TPG_MODE_FREE  = 2'b01,
        TPG_MODE_EDGE  = 2'b10,
        TPG_MODE_MATCH = 2'b11
    } tpg_mode_type;

    localparam logic [1:0] EDGE_FALL = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_NONE = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;

    typedef enum logic [1:0] {
        TPG_OS_IDLE   = 2'b00,
        TPG_OS_WAIT   = 2'b01,
        TPG_OS_ACTIVE = 2'b10
    } tpg_os_type;

endpackage

// file: tpg_timer.sv
// What this block does
// - periodic mode: first match clears counter, interrupt
// - periodic mode: second match interrupts, counting continues
// - period first+1, width second+1 count clocks
// - one-shot only in free/edge modes with enable
// - soft trigger or pin edge restarts counter
// - each trigger gives exactly one pulse
// - one-shot first match interrupts, toggles output
// - one-shot second match interrupts, toggles output
// - pulse starts after M+1, lasts N-M
// - overflow flag sticks until software clears
// - two-pin capture: first pin to second
// - one-pin: opposite edge first, valid second
// - edge mode: capture then clear counter
// - free mode wraps at top, sets overflow
// - mode code 11 selects periodic pulse
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module tpg_timer (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic [2:0]  addr,
    input  wire logic [15:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [15:0] rd_data,
    input  wire logic        first_capture_pin,
    input  wire logic        second_capture_pin,
    output logic             timer_output_pin,
    output logic             first_match_capture_irq,
    output logic             second_match_capture_irq
);

    typedef struct packed {
        logic [7:0]         div;
        logic               tick;
        logic [15:0]        cnt;
        logic [15:0]        cmp1;
        logic [15:0]        cmp2;
        tpg_pkg::tpg_mode_type mode;
        logic               ovf;
        logic               oe;
        logic               ose;
        logic [7:0]         cap;
        logic [2:0]         presc;
        tpg_pkg::tpg_os_type os;
        logic               out;
        logic               irq1;
        logic               irq2;
        logic [15:0]        rdat;
    } tpg_state_type;

    tpg_state_type s_q;
    tpg_state_type s_d;
    tpg_edge_if    edges ();

    tpg_pin_sync u_sync (
        .clk_sys            (clk_sys),
        .srst               (srst),
        .first_capture_pin  (first_capture_pin),
        .second_capture_pin (second_capture_pin),
        .edge_out           (edges.src)
    );

    // edge select decoding, shared by both pins
    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        edge_hit = (sel == tpg_pkg::EDGE_RISE && r) || (sel == tpg_pkg::EDGE_FALL && f) ||
                   (sel == tpg_pkg::EDGE_BOTH && (r || f));
    endfunction

    logic       first_valid;
    logic       first_opp;
    logic       second_valid;
    logic       os_cfg;
    logic       soft_trig;
    logic       trig;
    logic       m1;
    logic       m2;
    logic       running;
    logic [7:0] pmask;

    // ==========================================================
    // event decoding
    always_comb begin
        first_valid  = edge_hit(s_q.cap[tpg_pkg::CAP_FEDGE_LO +: 2],
                                edges.first_rise, edges.first_fall);
        // opposite edge exists only for a single-edge select
        first_opp    = edge_hit(~s_q.cap[tpg_pkg::CAP_FEDGE_LO +: 2] & 2'h1,
                                edges.first_rise, edges.first_fall) &&
                       !s_q.cap[tpg_pkg::CAP_FEDGE_LO + 1];
        second_valid = edge_hit(s_q.cap[tpg_pkg::CAP_SEDGE_LO +: 2],
                                edges.second_rise, edges.second_fall);
        os_cfg       = (s_q.mode == tpg_pkg::TPG_MODE_FREE || s_q.mode == tpg_pkg::TPG_MODE_EDGE)
                       && s_q.ose;
        soft_trig    = wr_en && addr == tpg_pkg::REG_OUT_CTRL && wr_data[tpg_pkg::OUT_OST_BIT];
        trig         = os_cfg && (soft_trig || first_valid);
        running      = s_q.mode != tpg_pkg::TPG_MODE_STOP;
        m1           = running && s_q.tick && s_q.cnt == s_q.cmp1 && !s_q.cap[tpg_pkg::CAP_FIRST_BIT];
        m2           = running && s_q.tick && s_q.cnt == s_q.cmp2 && !s_q.cap[tpg_pkg::CAP_SECOND_BIT];
        pmask        = (8'h01 << s_q.presc) - 8'h01;
    end

    // ==========================================================
    // next state
    always_comb begin
        s_d      = s_q;
        s_d.irq1 = 1'b0;
        s_d.irq2 = 1'b0;
        // count clock: one tick per 2^prescale system clocks
        s_d.div  = running ? s_q.div + 8'h01 : 8'h00;
        s_d.tick = running && ((s_q.div & pmask) == pmask);

        // counter; pin edges never act as count clock here
        if (!running) begin
            s_d.cnt = tpg_pkg::CNT_RESET;
        end else if (trig) begin
            s_d.cnt = tpg_pkg::CNT_RESET;
        end else if (s_q.mode == tpg_pkg::TPG_MODE_EDGE && first_valid) begin
            s_d.cnt = tpg_pkg::CNT_RESET;
        end else if (s_q.mode == tpg_pkg::TPG_MODE_MATCH && s_q.tick
                     && s_q.cnt == s_q.cmp1) begin
            s_d.cnt = tpg_pkg::CNT_RESET;
        end else if (s_q.tick) begin
            s_d.cnt = s_q.cnt + 16'h0001; // wraps at top
        end

        // compare match interrupts
        if (m1) begin
            s_d.irq1 = 1'b1;
        end
        if (m2) begin
            s_d.irq2 = 1'b1;
        end

        // register writes; capture below takes priority over them
        if (wr_en) begin
            unique case (addr)
                tpg_pkg::REG_CMP_FIRST:  s_d.cmp1 = wr_data;
                tpg_pkg::REG_CMP_SECOND: s_d.cmp2 = wr_data;
                tpg_pkg::REG_MODE_CTRL: begin
                    s_d.mode = tpg_pkg::tpg_mode_type'(wr_data[tpg_pkg::MODE_FIELD_LO +: 2]);
                    // writing zero clears, writing one leaves it
                    if (!wr_data[tpg_pkg::MODE_OVF_BIT]) begin
                        s_d.ovf = 1'b0;
                    end
                end
                tpg_pkg::REG_OUT_CTRL: begin
                    s_d.oe  = wr_data[tpg_pkg::OUT_ENABLE_BIT];
                    s_d.ose = wr_data[tpg_pkg::OUT_OSE_BIT];
                end
                tpg_pkg::REG_CAP_CFG:  s_d.cap   = wr_data[7:0];
                tpg_pkg::REG_PRESCALE: s_d.presc = wr_data[2:0];
                default: ;
            endcase
        end

        // overflow sets after the top value; set beats a clearing write
        if ((s_q.mode == tpg_pkg::TPG_MODE_FREE || s_q.mode == tpg_pkg::TPG_MODE_EDGE)
            && s_q.tick && s_q.cnt == tpg_pkg::CNT_TOP) begin
            s_d.ovf = 1'b1;
        end

        // captures in free-running and edge-restart modes
        if (s_q.mode == tpg_pkg::TPG_MODE_FREE || s_q.mode == tpg_pkg::TPG_MODE_EDGE) begin
            if (s_q.cap[tpg_pkg::CAP_SECOND_BIT] && first_valid) begin
                s_d.cmp2 = s_q.cnt;
                s_d.irq2 = 1'b1;
            end
            if (s_q.cap[tpg_pkg::CAP_FIRST_BIT]) begin
                if (s_q.cap[tpg_pkg::CAP_FSRC_BIT] && first_opp) begin
                    s_d.cmp1 = s_q.cnt; // no interrupt on the opposite edge
                end else if (!s_q.cap[tpg_pkg::CAP_FSRC_BIT] && second_valid) begin
                    s_d.cmp1 = s_q.cnt;
                    s_d.irq1 = 1'b1;
                end
            end
        end

        // one-shot sequencer: two toggles, then idle until the next trigger
        if (!os_cfg) begin
            s_d.os = tpg_pkg::TPG_OS_IDLE;
        end else if (trig) begin
            s_d.os  = tpg_pkg::TPG_OS_WAIT; // a retrigger mid-pulse restarts
            s_d.out = 1'b0;
        end else begin
            unique case (s_q.os)
                tpg_pkg::TPG_OS_IDLE: ;
                tpg_pkg::TPG_OS_WAIT: begin
                    if (m1 || m2) begin
                        s_d.out = ~s_q.out; // earlier compare value reached
                        s_d.os  = tpg_pkg::TPG_OS_ACTIVE;
                    end
                end
                tpg_pkg::TPG_OS_ACTIVE: begin
                    if (m1 || m2) begin
                        s_d.out = ~s_q.out; // later value ends the single pulse
                        s_d.os  = tpg_pkg::TPG_OS_IDLE;
                    end
                end
                default: s_d.os = tpg_pkg::TPG_OS_IDLE;
            endcase
        end

        // output level in the other modes
        if (s_q.mode == tpg_pkg::TPG_MODE_MATCH) begin
            // high while the next count is at or below the second value
            s_d.out = s_d.cnt <= s_q.cmp2; // equal values are illegal, not guarded
        end else if (!os_cfg && running && (m1 || m2)) begin
            s_d.out = ~s_q.out; // plain toggle on match in free and edge modes
        end else if (!running) begin
            s_d.out = 1'b0;
        end

        // read data valid in the cycle after the strobe only
        s_d.rdat = 16'h0000;
        if (rd_en) begin
            unique case (addr)
                tpg_pkg::REG_COUNTER:    s_d.rdat = s_q.cnt;
                tpg_pkg::REG_CMP_FIRST:  s_d.rdat = s_q.cmp1;
                tpg_pkg::REG_CMP_SECOND: s_d.rdat = s_q.cmp2;
                tpg_pkg::REG_MODE_CTRL:
                    s_d.rdat = {12'h000, s_q.mode, 1'b0, s_q.ovf};
                tpg_pkg::REG_OUT_CTRL:
                    s_d.rdat = {10'h000, s_q.ose, 4'h0, s_q.oe}; // trigger bit reads zero
                tpg_pkg::REG_CAP_CFG:    s_d.rdat = {8'h00, s_q.cap};
                tpg_pkg::REG_PRESCALE:   s_d.rdat = {13'h0000, s_q.presc};
                default:                 s_d.rdat = 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q       <= '0;
            s_q.cnt   <= tpg_pkg::CNT_RESET;
            s_q.cmp1  <= tpg_pkg::CMP_RESET;
            s_q.cmp2  <= tpg_pkg::CMP_RESET;
            s_q.cap   <= tpg_pkg::CAP_RESET;
            s_q.presc <= tpg_pkg::PRESC_RESET;
            s_q.mode  <= tpg_pkg::TPG_MODE_STOP;
            s_q.os    <= tpg_pkg::TPG_OS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, all straight from flops; pin gated by the output enable
    always_comb begin
        rd_data                  = s_q.rdat;
        first_match_capture_irq  = s_q.irq1;
        second_match_capture_irq = s_q.irq2;
    end

    logic pin_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= s_d.out && s_d.oe;
        end
    end
    assign timer_output_pin = pin_q;

    // ==========================================================
    // checks
    ppg_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
        (s_q.mode == tpg_pkg::TPG_MODE_MATCH && s_q.tick && s_q.cnt == s_q.cmp1
         && !s_q.cap[0] && !wr_en) |=> s_q.cnt == 16'h0000 && s_q.irq1)
        else $error("periodic first match did not clear and interrupt");

    ppg_second_a: assert property (@(posedge clk_sys) disable iff (srst)
        (s_q.mode == tpg_pkg::TPG_MODE_MATCH && s_q.tick && s_q.cnt == s_q.cmp2
         && s_q.cmp2 != s_q.cmp1 && !s_q.cap[2] && !wr_en)
        |=> s_q.irq2 && s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("periodic second match wrong");

    ppg_level_a: assert property (@(posedge clk_sys) disable iff (srst)
        ($past(s_q.mode) == tpg_pkg::TPG_MODE_MATCH && s_q.mode == tpg_pkg::TPG_MODE_MATCH
         && $stable(s_q.cmp2)) |-> s_q.out == (s_q.cnt <= s_q.cmp2))
        else $error("periodic output level does not follow counter");

    free_wrap_a: assert property (@(posedge clk_sys) disable iff (srst)
        (s_q.mode == tpg_pkg::TPG_MODE_FREE && s_q.tick && s_q.cnt == 16'hFFFF
         && !trig && !wr_en) |=> s_q.cnt == 16'h0000 && s_q.ovf)
        else $error("free-running wrap or overflow flag wrong");

    ovf_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
        (s_q.ovf && !(wr_en && addr == tpg_pkg::REG_MODE_CTRL)) |=> s_q.ovf)
        else $error("overflow flag dropped without a clearing write");

    os_trig_a: assert property (@(posedge clk_sys) disable iff (srst)
        (trig && !wr_en) |=> s_q.cnt == 16'h0000 && s_q.os == tpg_pkg::TPG_OS_WAIT)
        else $error("one-shot trigger did not restart counter");

    os_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
        !os_cfg |=> s_q.os == tpg_pkg::TPG_OS_IDLE || os_cfg)
        else $error("one-shot active outside its modes");

    os_first_a: assert property (@(posedge clk_sys) disable iff (srst)
        (s_q.os == tpg_pkg::TPG_OS_WAIT && os_cfg && !trig && m1 && !wr_en)
        |=> s_q.irq1 && s_q.out != $past(s_q.out))
        else $error("one-shot first match did not toggle");

    os_end_a: assert property (@(posedge clk_sys) disable iff (srst)
        (s_q.os == tpg_pkg::TPG_OS_ACTIVE && os_cfg && !trig && (m1 || m2) && !wr_en)
        |=> s_q.os == tpg_pkg::TPG_OS_IDLE ##1 (s_q.os == tpg_pkg::TPG_OS_IDLE || $past(trig)))
        else $error("one-shot did not end after its single pulse");

    cap_second_a: assert property (@(posedge clk_sys) disable iff (srst)
        (s_q.mode == tpg_pkg::TPG_MODE_FREE && s_q.cap[2] && first_valid)
        |=> s_q.cmp2 == $past(s_q.cnt) && s_q.irq2)
        else $error("first pin edge did not capture into second register");

    edge_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
        (s_q.mode == tpg_pkg::TPG_MODE_EDGE && first_valid && !wr_en) |=> s_q.cnt == 16'h0000)
        else $error("edge restart mode did not clear counter");

endmodule

`default_nettype wire
